// ### rtl/dpa_pkg.sv
package dpa_pkg;

  // ==========================================================================
  // Instruction fields
  // ==========================================================================
  localparam int unsigned OPC_MSB = 31;
  localparam int unsigned OPC_LSB = 26;
  localparam int unsigned RS_MSB = 25;
  localparam int unsigned RS_LSB = 21;
  localparam int unsigned RT_MSB = 20;
  localparam int unsigned RT_LSB = 16;
  localparam int unsigned AC_MSB = 12;
  localparam int unsigned AC_LSB = 11;
  localparam int unsigned SUB_MSB = 10;
  localparam int unsigned SUB_LSB = 6;
  localparam int unsigned FN_MSB = 5;
  localparam int unsigned FN_LSB = 0;

  localparam logic [5:0] EXT_MAJOR_OPC = 6'h1F;
  localparam logic [4:0] SUB_SIDE_UPPER = 5'h03;
  localparam logic [4:0] SUB_SIDE_LOWER = 5'h07;
  localparam logic [4:0] SUB_CROSS = 5'h08;
  localparam logic [4:0] SUB_QUAD_SUB = 5'h01;
  localparam logic [5:0] FN_WIDE = 6'h34;
  localparam logic [5:0] FN_NARROW = 6'h30;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned XLEN = 64;
  localparam int unsigned WORD = 32;
  localparam int unsigned NUM_ACC = 4;
  localparam int unsigned ACC_SEL_W = 2;
  localparam int unsigned REG_IDX_W = 5;
  localparam int unsigned BYTE_SUM_W = 18;
  localparam int unsigned HALF_SUM_W = 34;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    DPA_OP_NONE,
    DPA_OP_UPPER_SIDE_BYTE,
    DPA_OP_LOWER_SIDE_BYTE,
    DPA_OP_UPPER_PAIR_BYTE,
    DPA_OP_LOWER_PAIR_BYTE,
    DPA_OP_CROSS_HALF,
    DPA_OP_QUAD_HALF_SUB
  } dpa_op_t;

  typedef struct packed {
    logic [XLEN-1:0] hi;
    logic [XLEN-1:0] lo;
  } dpa_acc_t;

  typedef struct packed {
    logic valid;
    logic [WORD-1:0] instr;
    logic [XLEN-1:0] src_a;
    logic [XLEN-1:0] src_b;
    logic dsp_enable;
  } dpa_req_t;

  typedef struct packed {
    logic done;
    logic rsvd_instr_exc;
    logic dsp_disabled_exc;
    logic [ACC_SEL_W-1:0] acc_sel;
    dpa_acc_t acc;
  } dpa_rsp_t;

endpackage

// ### rtl/dpa_decode.sv
`timescale 1ns/100ps
`default_nettype none
module dpa_decode
  import dpa_pkg::*;
(
  input wire logic [dpa_pkg::WORD-1:0] instr,
  output dpa_pkg::dpa_op_t op,
  output logic is_ext_major
);
  import dpa_pkg::*;

  logic [5:0] major;
  logic [4:0] sub;
  logic [5:0] fn;

  assign major = instr[OPC_MSB:OPC_LSB];
  assign sub = instr[SUB_MSB:SUB_LSB];
  assign fn = instr[FN_MSB:FN_LSB];
  assign is_ext_major = (major == EXT_MAJOR_OPC);

  // ==========================================================================
  // Opcode match
  // ==========================================================================
  always_comb begin
    op = DPA_OP_NONE;
    if (is_ext_major) begin
      if (fn == FN_WIDE && sub == SUB_SIDE_UPPER) begin
        op = DPA_OP_UPPER_SIDE_BYTE;
      end else if (fn == FN_WIDE && sub == SUB_SIDE_LOWER) begin
        op = DPA_OP_LOWER_SIDE_BYTE; // see RQ1
      end else if (fn == FN_NARROW && sub == SUB_SIDE_UPPER) begin
        op = DPA_OP_UPPER_PAIR_BYTE; // see RQ2
      end else if (fn == FN_NARROW && sub == SUB_SIDE_LOWER) begin
        op = DPA_OP_LOWER_PAIR_BYTE; // see RQ3
      end else if (fn == FN_NARROW && sub == SUB_CROSS) begin
        op = DPA_OP_CROSS_HALF; // see RQ4
      end else if (fn == FN_WIDE && sub == SUB_QUAD_SUB) begin
        op = DPA_OP_QUAD_HALF_SUB; // see RQ5
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/dpa_dotp.sv
`timescale 1ns/100ps
`default_nettype none
module dpa_dotp
  import dpa_pkg::*;
(
  input wire dpa_pkg::dpa_op_t op,
  input wire logic [dpa_pkg::XLEN-1:0] src_a,
  input wire logic [dpa_pkg::XLEN-1:0] src_b,
  output logic [dpa_pkg::XLEN-1:0] dotp
);
  import dpa_pkg::*;

  logic [15:0] bprod [8];
  logic signed [31:0] hprod [4];
  logic signed [31:0] xprod [2];

  // ==========================================================================
  // Element multipliers
  // ==========================================================================
  // Zero bit prefixed so signed-safe 9x9 multiply stays unsigned
  for (genvar i = 0; i < 8; i++) begin : g_byte
    logic [17:0] wide;
    assign wide = {1'b0, src_a[i*8 +: 8]} * {1'b0, src_b[i*8 +: 8]}; // see RQ17
    assign bprod[i] = wide[15:0];
  end
  for (genvar j = 0; j < 4; j++) begin : g_half
    assign hprod[j] = $signed(src_a[j*16 +: 16]) * $signed(src_b[j*16 +: 16]);
  end
  assign xprod[0] = $signed(src_a[31:16]) * $signed(src_b[15:0]); // see RQ12
  assign xprod[1] = $signed(src_a[15:0]) * $signed(src_b[31:16]);

  // ==========================================================================
  // Dot product, widened to 64 bits
  // ==========================================================================
  always_comb begin
    logic [BYTE_SUM_W-1:0] bsum;
    logic signed [HALF_SUM_W-1:0] hsum;
    bsum = '0;
    hsum = '0;
    dotp = '0;
    unique case (op)
      DPA_OP_UPPER_SIDE_BYTE: begin
        bsum = BYTE_SUM_W'(bprod[7]) + BYTE_SUM_W'(bprod[6]) + BYTE_SUM_W'(bprod[5])
             + BYTE_SUM_W'(bprod[4]); // see RQ8
        dotp = XLEN'(bsum);
      end
      DPA_OP_LOWER_SIDE_BYTE: begin
        bsum = BYTE_SUM_W'(bprod[3]) + BYTE_SUM_W'(bprod[2]) + BYTE_SUM_W'(bprod[1])
             + BYTE_SUM_W'(bprod[0]); // see RQ7
        dotp = XLEN'(bsum);
      end
      DPA_OP_UPPER_PAIR_BYTE: dotp = XLEN'(bprod[3]) + XLEN'(bprod[2]); // see RQ9
      DPA_OP_LOWER_PAIR_BYTE: dotp = XLEN'(bprod[1]) + XLEN'(bprod[0]); // see RQ10
      DPA_OP_CROSS_HALF: begin
        hsum = HALF_SUM_W'(xprod[0]) + HALF_SUM_W'(xprod[1]); // see RQ12
        dotp = XLEN'(hsum);
      end
      DPA_OP_QUAD_HALF_SUB: begin
        hsum = HALF_SUM_W'(hprod[0]) + HALF_SUM_W'(hprod[1]) + HALF_SUM_W'(hprod[2])
             + HALF_SUM_W'(hprod[3]); // see RQ13
        dotp = XLEN'(hsum);
      end
      default: dotp = '0;
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/dpa_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RQ1 - Decode lower-side byte accumulate opcode
// RQ2 - Decode upper-pair byte accumulate opcode
// RQ3 - Decode lower-pair byte accumulate opcode
// RQ4 - Decode cross halfword accumulate opcode
// RQ5 - Decode quad halfword subtract opcode
// RQ6 - Selector picks accumulator 0..3; 0 original
// RQ7 - Low four bytes, unsigned, add 128-bit
// RQ8 - High four bytes, unsigned, add 128-bit
// RQ9 - Bytes 31..16 products added, 64-bit
// RQ10 - Bytes 15..0 products added, 64-bit
// RQ11 - 64-bit forms sign-extend each half
// RQ12 - Cross signed halfword products accumulated
// RQ13 - Four signed halfword products subtracted, 128-bit
// RQ14 - Overflow flag field never touched
// RQ15 - Reserved or disabled raises exception instead
// RQ16 - No data-dependent exceptions; wrap silently
// RQ17 - Byte multiply with zero-prefixed operands
// RQ18 - Both halves written together atomically
module dpa_unit
  import dpa_pkg::*;
#(
  parameter int unsigned N_ACC = dpa_pkg::NUM_ACC
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dpa_pkg::dpa_req_t req,
  input wire logic [dpa_pkg::ACC_SEL_W-1:0] rd_sel,
  output dpa_pkg::dpa_rsp_t rsp,
  output dpa_pkg::dpa_acc_t rd_acc
);
  import dpa_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    dpa_acc_t [N_ACC-1:0] acc;
    dpa_rsp_t rsp;
    dpa_acc_t rd;
  } dpa_state_t;

  dpa_state_t state_ff;
  dpa_state_t nxt_state;

  dpa_op_t op;
  logic is_ext_major;
  logic [XLEN-1:0] dotp;
  logic [ACC_SEL_W-1:0] sel;

  assign sel = req.instr[AC_MSB:AC_LSB];

  dpa_decode u_decode (
    .instr(req.instr),
    .op(op),
    .is_ext_major(is_ext_major)
  );

  dpa_dotp u_dotp (
    .op(op),
    .src_a(req.src_a),
    .src_b(req.src_b),
    .dotp(dotp)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Result computed and written in the issue cycle; one-cycle latency
  always_comb begin
    logic [2*XLEN-1:0] cur;
    logic [2*XLEN-1:0] wide_res;
    logic [XLEN-1:0] narrow_res;
    logic [XLEN-1:0] ext64;
    logic write;
    cur = '0;
    wide_res = '0;
    narrow_res = '0;
    ext64 = '0;
    write = 1'b0;
    nxt_state = state_ff;
    nxt_state.rsp.done = 1'b0;
    nxt_state.rsp.rsvd_instr_exc = 1'b0;
    nxt_state.rsp.dsp_disabled_exc = 1'b0;
    if (req.valid) begin
      nxt_state.rsp.acc_sel = sel;
      if (op == DPA_OP_NONE) begin
        nxt_state.rsp.rsvd_instr_exc = 1'b1; // see RQ15
      end else if (!req.dsp_enable) begin
        nxt_state.rsp.dsp_disabled_exc = 1'b1; // see RQ15
      end else begin
        write = 1'b1;
      end
    end
    if (write) begin
      // Selector indexes pair 0..3 directly, pair 0 is the legacy one
      cur = {state_ff.acc[sel].hi, state_ff.acc[sel].lo}; // see RQ6
      // Quad halfword subtract needs 128-bit sign extension, side byte ones zero
      ext64 = dotp;
      unique case (op)
        DPA_OP_UPPER_SIDE_BYTE, DPA_OP_LOWER_SIDE_BYTE: begin
          wide_res = cur + {{XLEN{1'b0}}, ext64}; // see RQ7, see RQ8, see RQ16
          nxt_state.acc[sel] = wide_res; // see RQ18
        end
        DPA_OP_QUAD_HALF_SUB: begin
          wide_res = cur - {{XLEN{ext64[XLEN-1]}}, ext64}; // see RQ13, see RQ16
          nxt_state.acc[sel] = wide_res; // see RQ18
        end
        default: begin
          // 64-bit forms use only the low word of each half
          narrow_res = {state_ff.acc[sel].hi[WORD-1:0], state_ff.acc[sel].lo[WORD-1:0]}
                     + ext64; // see RQ11, see RQ16
          nxt_state.acc[sel].hi = {{WORD{narrow_res[XLEN-1]}}, narrow_res[XLEN-1:WORD]}; // see RQ11
          nxt_state.acc[sel].lo = {{WORD{narrow_res[WORD-1]}}, narrow_res[WORD-1:0]}; // see RQ18
        end
      endcase
      nxt_state.rsp.done = 1'b1;
    end
    // Flag field lives outside this unit and is never driven here (see RQ14)
    // Result view moves only with an issued word; an idle selector must not disturb it
    if (req.valid) begin
      nxt_state.rsp.acc = nxt_state.acc[sel];
    end
    // Read port for the pipeline's accumulator moves
    nxt_state.rd = nxt_state.acc[rd_sel];
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rsp = state_ff.rsp;
  assign rd_acc = state_ff.rd;
endmodule
`default_nettype wire

// ### tb/dpa_unit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dpa_unit_monitor
  import dpa_pkg::*;
#(
  parameter int unsigned N_ACC = 4
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dpa_pkg::dpa_req_t req,
  input wire logic [1:0] rd_sel,
  input wire dpa_pkg::dpa_rsp_t rsp,
  input wire dpa_pkg::dpa_acc_t rd_acc
);
  // ==========
  // Decode view of the issued word
  logic [10:0] sf;
  logic ok;
  logic go;
  assign sf = req.instr[10:0];
  assign ok = req.instr[31:26] == 6'h1F && sf inside {11'h0F4, 11'h1F4, 11'h074, 11'h0F0, 11'h1F0, 11'h230};
  assign go = req.valid && ok && req.dsp_enable;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Checks
  property p_one; req.valid |=> $onehot({rsp.done, rsp.rsvd_instr_exc, rsp.dsp_disabled_exc}); endproperty
  a_one: assert property (p_one) else $error("not exactly one answer");
  property p_rsvd; req.valid && !ok |=> rsp.rsvd_instr_exc; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved word not refused");
  property p_dis; req.valid && ok && !req.dsp_enable |=> rsp.dsp_disabled_exc; endproperty
  a_dis: assert property (p_dis) else $error("disabled unit not refused");
  property p_done; go |=> rsp.done; endproperty
  a_done: assert property (p_done) else $error("legal word not executed");
  property p_sel; req.valid |=> rsp.acc_sel == $past(req.instr[12:11]); endproperty
  a_sel: assert property (p_sel) else $error("wrong selector echoed");
  property p_sext; go && sf[5:0] == 6'h30 |=> rsp.acc.hi[63:32] == {32{rsp.acc.hi[31]}}
    && rsp.acc.lo[63:32] == {32{rsp.acc.lo[31]}}; endproperty
  a_sext: assert property (p_sext) else $error("halves not sign extended");
  property p_hold; !req.valid |=> $stable(rsp.acc) && $stable(rsp.acc_sel); endproperty
  a_hold: assert property (p_hold) else $error("result moved while idle");
  property p_rd; rsp.done && !req.valid && rd_sel == rsp.acc_sel |=> rd_acc == $past(rsp.acc); endproperty
  a_rd: assert property (p_rd) else $error("read port disagrees");
endmodule
bind dpa_unit dpa_unit_monitor #(.N_ACC(N_ACC)) u_mon (.core_clk(core_clk), .arst_n(arst_n),
  .req(req), .rd_sel(rd_sel), .rsp(rsp), .rd_acc(rd_acc));
`default_nettype wire

// ### tb/dpa_issue.sv
`timescale 1ns/100ps
`default_nettype none
module dpa_issue
  import dpa_pkg::*;
(
  input wire logic core_clk,
  output var dpa_pkg::dpa_req_t req
);
  // ==========
  // Issue slot, one cycle per word
  initial req = '0;
  // Release scrambles operands so a stale value never looks live
  task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b, input logic en);
    @(posedge core_clk);
    #1 req = {1'b1, ins, a, b, en};
    @(posedge core_clk);
    #1 req = {1'b0, ~ins, ~a, ~b, ~en};
  endtask
endmodule
`default_nettype wire

// ### tb/dpa_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module dpa_unit_test;
  import dpa_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] rd_sel = 2'h0;
  dpa_req_t req;
  dpa_rsp_t rsp;
  dpa_acc_t rd_acc;
  dpa_acc_t acc [4] = '{default: '0};
  logic [63:0] ea;
  logic [63:0] eb;
  int miscompares = 0;
  int num_checks = 0;
  always #12.5 core_clk = ~core_clk;
  dpa_issue u_iss (.core_clk(core_clk), .req(req));
  dpa_unit uut (.core_clk(core_clk), .arst_n(arst_n), .req(req), .rd_sel(rd_sel), .rsp(rsp), .rd_acc(rd_acc));
  // ==========
  // Reference arithmetic; zero prefix keeps bytes unsigned
  function automatic logic signed [63:0] ub(input int k);
    return $signed({1'b0, ea[8*k+:8]}) * $signed({1'b0, eb[8*k+:8]});
  endfunction
  function automatic logic signed [63:0] sh(input int i, input int j);
    return $signed(ea[16*i+:16]) * $signed(eb[16*j+:16]);
  endfunction
  function automatic dpa_acc_t nxt(input dpa_acc_t c, input logic [10:0] sf);
    logic signed [63:0] d;
    logic [63:0] t;
    d = '0;
    for (int i = 0; i < 4; i++) begin
      if (sf == 11'h0F4) d = d + ub(i + 4);
      if (sf == 11'h1F4) d = d + ub(i);
      if (sf == 11'h074) d = d + sh(i, i);
    end
    case (sf)
      11'h0F0: d = ub(2) + ub(3);
      11'h1F0: d = ub(0) + ub(1);
      11'h230: d = sh(1, 0) + sh(0, 1);
      11'h074: return c - {{64{d[63]}}, d};
      default: return c + {64'h0, d};
    endcase
    t = {c.hi[31:0], c.lo[31:0]} + d;
    return {{32{t[63]}}, t[63:32], {32{t[31]}}, t[31:0]};
  endfunction
  // ==========
  // Shared compare and issue
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [5:0] mj, input logic [10:0] sf, input logic [1:0] ac, input logic [63:0] a,
    input logic [63:0] b, input logic en);
    logic [2:0] k;
    ea = a;
    eb = b;
    k = 3'h4;
    if (mj != 6'h1F || !(sf inside {11'h0F4, 11'h1F4, 11'h074, 11'h0F0, 11'h1F0, 11'h230})) k = 3'h2;
    else if (!en) k = 3'h1;
    else acc[ac] = nxt(acc[ac], sf);
    rd_sel = ac;
    u_iss.issue({mj, 10'h000, 3'h0, ac, sf}, a, b, en);
    chk({rsp.done, rsp.rsvd_instr_exc, rsp.dsp_disabled_exc}, k);
    chk(rsp.acc_sel, ac);
    if (k == 3'h4) chk(rsp.acc, acc[ac]);
  endtask
  // ==========
  // Scenarios
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      #1 rd_sel = i[1:0];
      repeat (2) @(posedge core_clk);
      #1 chk(rd_acc, acc[i]);
    end
  endtask
  task automatic t_bytes();
    logic [10:0] f [4] = '{11'h0F4, 11'h1F4, 11'h0F0, 11'h1F0};
    for (int i = 0; i < 4; i++) begin
      run(6'h1F, f[i], i[1:0], '1, '1, 1'b1);
      run(6'h1F, f[i], 2'(i + 1), 64'h8001_7F02_FE03_0104, 64'h0380_02FF_80FE_0401, 1'b1);
    end
  endtask
  // Subtract drives the sum negative, so the 64-bit forms then wrap
  task automatic t_half();
    for (int i = 0; i < 4; i++) begin
      run(6'h1F, 11'h074, i[1:0], 64'h8000_7FFF_8000_0001, 64'h7FFF_7FFF_8000_FFFF, 1'b1);
      run(6'h1F, 11'h230, i[1:0], 64'h1234_5678_8000_7FFF, 64'h0000_0000_8000_7FFF, 1'b1);
      run(6'h1F, 11'h1F0, i[1:0], '1, '1, 1'b1);
    end
  endtask
  task automatic t_exc();
    run(6'h00, 11'h0F4, 2'h1, '1, '1, 1'b1);
    run(6'h1F, 11'h070, 2'h2, '1, '1, 1'b1);
    run(6'h1F, 11'h230, 2'h3, '1, '1, 1'b0);
    run(6'h1F, 11'h234, 2'h3, '1, '1, 1'b0);
    t_read();
  endtask
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset, then every scenario in turn
  initial begin
    repeat (5) @(posedge core_clk);
    #1 arst_n = 1'b1;
    t_read();
    t_bytes();
    t_half();
    t_exc();
    close_out();
  end
endmodule
`default_nettype wire
